// [shared/umr_regs.vh]
// Purpose: constants for the channel A mode-zero control block
// Assumes: 32-bit AXI4-Lite register words, byte addresses
// Notes: all offsets are byte addresses of aligned words
`ifndef UMR_REGS_VH
`define UMR_REGS_VH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define UMR_OFF_MODE0 4'h0
`define UMR_OFF_MODE1 4'h4
`define UMR_OFF_CMD 4'h8
`define UMR_OFF_STAT 4'hC
`define UMR_ADDR_W 4
// ------------------------------------------------------------
// mode-zero fields
// ------------------------------------------------------------
`define UMR_WDOG_BIT 7
`define UMR_RXI_BIT 6
`define UMR_TXI_HI 5
`define UMR_TXI_LO 4
`define UMR_DEPTH_BIT 3
`define UMR_TEST_BIT 1
`define UMR_MODE0_RST 8'h00
`define UMR_MODE1_RST 8'h00
// ------------------------------------------------------------
// commands, baud groups, timing
// ------------------------------------------------------------
`define UMR_CMD_PTR0 4'hB
`define UMR_CMD_PTR1 4'h1
`define UMR_BAUD_NORM 3'h0
`define UMR_BAUD_EXT1 3'h1
`define UMR_BAUD_EXT2 3'h4
`define UMR_WDOG_BITS 7'h40
// ------------------------------------------------------------
// interrupt status bits
// ------------------------------------------------------------
`define UMR_IRQ_RX 0
`define UMR_IRQ_TX 1
`define UMR_IRQ_WDOG 2
`define UMR_IRQ_W 3
`endif

// [core/umr_wdog.v]
// Purpose: receiver idle watchdog on bit-clock ticks
// Assumes: bit tick is a one-cycle pulse in the CLK_SYS domain
// Notes: timeout is held until the FIFO is read
`timescale 1ns/1ps
module umr_wdog (
  // clock and reset
  input wire clk,
  input wire nrst,
  // controls
  input wire enable,
  input wire bit_tick,
  input wire fifo_access,
  input wire fifo_read,
  input wire char_rx,
  input wire has_data,
  // result
  output reg timeout_q
);
`include "umr_regs.vh"
  reg [6:0] count_q;
  // ------------------------------------------------------------
  // bit-period counter
  // ------------------------------------------------------------
  // restart on any access so a busy FIFO never times out
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= 7'h00;
      timeout_q <= 1'b0;
    end else begin
      if (fifo_access || char_rx || !enable || !has_data) begin
        count_q <= 7'h00;
      end else if (bit_tick && count_q != `UMR_WDOG_BITS) begin
        count_q <= count_q + 7'h01;
      end
      if (fifo_read || !enable) begin
        timeout_q <= 1'b0;
      end else if (enable && has_data && count_q == `UMR_WDOG_BITS) begin
        timeout_q <= 1'b1;
      end
    end
  end
endmodule // umr_wdog

// [core/umr_level.v]
// Purpose: FIFO fill threshold compare for receive and transmit
// Assumes: levels are byte counts 0..16
// Notes: threshold is latched on FIFO traffic or while both are empty
`timescale 1ns/1ps
module umr_level (
  // clock and reset
  input wire clk,
  input wire nrst,
  // settings
  input wire [1:0] rx_code,
  input wire [1:0] tx_code,
  input wire depth16,
  input wire update,
  // fill state
  input wire [4:0] rx_level,
  input wire [4:0] tx_level,
  // requests
  output wire rx_req,
  output wire tx_req
);
  reg [1:0] rx_code_q;
  reg [1:0] tx_code_q;
  reg [4:0] rx_th;
  reg [4:0] tx_th;
  wire [4:0] size;
  wire [4:0] tx_empty;
  assign size = depth16 ? 5'h10 : 5'h08;
  assign tx_empty = size - tx_level;
  // ------------------------------------------------------------
  // applied codes
  // ------------------------------------------------------------
  // a change mid-stream waits for the next FIFO access
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_code_q <= 2'h0;
      tx_code_q <= 2'h0;
    end else if (update) begin
      rx_code_q <= rx_code;
      tx_code_q <= tx_code;
    end
  end
  // code to byte thresholds
  always @* begin
    case (rx_code_q)
      2'h0: rx_th = 5'h01;
      2'h1: rx_th = depth16 ? 5'h08 : 5'h03;
      2'h2: rx_th = depth16 ? 5'h0C : 5'h06;
      default: rx_th = size;
    endcase
    case (tx_code_q)
      2'h0: tx_th = size;
      2'h1: tx_th = depth16 ? 5'h08 : 5'h04;
      2'h2: tx_th = depth16 ? 5'h0C : 5'h06;
      default: tx_th = 5'h01;
    endcase
  end
  assign rx_req = rx_level >= rx_th;
  assign tx_req = tx_empty >= tx_th;
endmodule // umr_level

// [core/umr_ctrl.v]
// Purpose: channel A mode-zero register and FIFO interrupt levels
// Assumes: FIFO fill counts and strobes arrive on CLK_SYS
// Notes: bit clock tick is an async pin, synchronised here
//
// Operation
// - bit 7 enables receiver watchdog
// - watchdog fires after 64 idle bit periods
// - timeout shows as receive-data-available interrupt
// - receive threshold from mode0 bit6, mode1 bit6
// - default receive level is one byte
// - bits 5:4 choose transmit empty threshold
// - empty transmit FIFO interrupts once enabled
// - code 00 means transmit FIFO fully empty
// - one written byte drops default transmit request
// - bit 3 picks 8 or 16 depth
// - bits 2 and 0 pick baud group
// - mode0 reached only with pointer at zero
// - transmit codes map to fixed empty counts
// - thresholds apply at next FIFO access or while both FIFOs are empty
`timescale 1ns/1ps
module umr_ctrl (
  // clock and reset
  input wire CLK_SYS,
  input wire NRST,
  // axi4-lite write address
  input wire [3:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  // axi4-lite write data
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  // axi4-lite write response
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  // axi4-lite read address
  input wire [3:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  // axi4-lite read data
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // fifo side
  input wire [4:0] RX_LEVEL,
  input wire [4:0] TX_LEVEL,
  input wire RX_FIFO_READ,
  input wire RX_CHAR_IN,
  input wire TX_FIFO_WRITE,
  input wire TX_ENABLE,
  input wire RX_BIT_TICK,
  // outputs to channel logic
  output reg FIFO_DEPTH_16,
  output reg [2:0] BAUD_GROUP,
  output reg RX_DATA_AVAILABLE,
  output reg TX_SPACE_AVAILABLE,
  output reg IRQ
);
`include "umr_regs.vh"
  // ------------------------------------------------------------
  // register map overview
  // ------------------------------------------------------------
  // word 0: mode0 or mode1, steered by the mode pointer
  // word 1: mode1 reached directly, pointer left alone
  // word 2: command code in bits 7:4, pointer state reads in bit 0
  // word 3: status bits 2:0 write-one-to-clear, mask in bits 10:8
  // status bit 0: receive request, level or idle timeout
  // status bit 1: transmit request, gated by the enable pin
  // status bit 2: idle timeout alone, for software that polls it
  // unmapped words answer with a slave error and change nothing
  // a write without byte lane 0 is answered but ignored
  // the pointer resets to mode1, so a stray write after reset
  // lands in mode1 and never disturbs the watchdog or fifo depth
  // thresholds are latched inside the level block, so software
  // that changes them with data queued sees the old level until
  // the next fifo access; this keeps the request glitch free
  // bus handshakes never wait on the other side's valid, so a
  // master that holds valid high always makes progress
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [7:0] mode0_q;
  reg [7:0] mode1_q;
  reg ptr_zero_q;
  reg [`UMR_IRQ_W-1:0] irq_stat_q;
  reg [`UMR_IRQ_W-1:0] irq_mask_q;
  reg [3:0] aw_addr_q;
  reg aw_have_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_have_q;
  reg tick_s1_q;
  reg tick_s2_q;
  reg tick_s3_q;
  reg rx_req_q;
  reg tx_req_q;
  reg [31:0] rd_d;
  reg [1:0] rresp_d;
  wire wr_go;
  wire bit_tick;
  wire fifo_access;
  wire both_empty;
  wire level_update;
  wire rx_req;
  wire tx_req;
  wire wdog_to;
  wire rx_avail;
  wire [`UMR_IRQ_W-1:0] irq_evt;
  wire [`UMR_IRQ_W-1:0] clr_bits;
  wire wr_mode0;
  wire wr_mode1;
  wire wr_cmd;
  wire wr_stat;
  wire wr_bad;
  wire [7:0] mode0_wr;
  // ------------------------------------------------------------
  // bit tick synchroniser
  // ------------------------------------------------------------
  // tick is asynchronous; stages two and three feed the edge detector
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
    end else begin
      tick_s1_q <= RX_BIT_TICK;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end
  assign bit_tick = tick_s2_q & ~tick_s3_q;
  // ------------------------------------------------------------
  // axi4-lite write path
  // ------------------------------------------------------------
  assign wr_go = aw_have_q && w_have_q && !S_AXI_BVALID;
  assign wr_mode0 = wr_go && aw_addr_q == `UMR_OFF_MODE0 && w_strb_q[0];
  assign wr_mode1 = wr_go && aw_addr_q == `UMR_OFF_MODE1 && w_strb_q[0];
  assign wr_cmd = wr_go && aw_addr_q == `UMR_OFF_CMD && w_strb_q[0];
  assign wr_stat = wr_go && aw_addr_q == `UMR_OFF_STAT && w_strb_q[0];
  assign wr_bad = aw_addr_q != `UMR_OFF_MODE0 &&
                  aw_addr_q != `UMR_OFF_MODE1 &&
                  aw_addr_q != `UMR_OFF_CMD && aw_addr_q != `UMR_OFF_STAT;
  // test bit forced low whatever the host writes
  assign mode0_wr = w_data_q[7:0] & ~(8'h01 << `UMR_TEST_BIT);
  // address and data may arrive in either order
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else begin
      S_AXI_AWREADY <= !aw_have_q && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_have_q && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {S_AXI_AWADDR[3:2], 2'h0};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_bad ? 2'h2 : 2'h0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // mode registers and pointer
  // ------------------------------------------------------------
  // mode0 shares its address with mode1; the pointer steers writes
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      mode0_q <= `UMR_MODE0_RST;
      mode1_q <= `UMR_MODE1_RST;
      ptr_zero_q <= 1'b0;
      irq_mask_q <= {`UMR_IRQ_W{1'b0}};
    end else begin
      if (wr_cmd && w_data_q[7:4] == `UMR_CMD_PTR0) begin
        ptr_zero_q <= 1'b1;
      end else if (wr_cmd && w_data_q[7:4] == `UMR_CMD_PTR1) begin
        ptr_zero_q <= 1'b0;
      end
      if (wr_mode0 && ptr_zero_q) begin
        mode0_q <= mode0_wr;
      end else if (wr_mode0) begin
        mode1_q <= w_data_q[7:0];
      end
      if (wr_mode1) begin
        mode1_q <= w_data_q[7:0];
      end
      if (wr_stat && w_strb_q[1]) begin
        irq_mask_q <= w_data_q[8 +: `UMR_IRQ_W];
      end
    end
  end
  // ------------------------------------------------------------
  // thresholds and watchdog
  // ------------------------------------------------------------
  assign fifo_access = RX_FIFO_READ || TX_FIFO_WRITE;
  assign both_empty = RX_LEVEL == 5'h00 && TX_LEVEL == 5'h00;
  assign level_update = fifo_access || both_empty;
  umr_level u_level (
    .clk(CLK_SYS),
    .nrst(NRST),
    .rx_code({mode0_q[`UMR_RXI_BIT], mode1_q[`UMR_RXI_BIT]}),
    .tx_code(mode0_q[`UMR_TXI_HI:`UMR_TXI_LO]),
    .depth16(mode0_q[`UMR_DEPTH_BIT]),
    .update(level_update),
    .rx_level(RX_LEVEL),
    .tx_level(TX_LEVEL),
    .rx_req(rx_req),
    .tx_req(tx_req)
  );
  umr_wdog u_wdog (
    .clk(CLK_SYS),
    .nrst(NRST),
    .enable(mode0_q[`UMR_WDOG_BIT]),
    .bit_tick(bit_tick),
    .fifo_access(fifo_access),
    .fifo_read(RX_FIFO_READ),
    .char_rx(RX_CHAR_IN),
    .has_data(RX_LEVEL != 5'h00),
    .timeout_q(wdog_to)
  );
  // timeout merges into the receive request
  assign rx_avail = rx_req || wdog_to;
  assign irq_evt = {wdog_to, tx_req_q, rx_req_q};
  assign clr_bits = (wr_stat && w_strb_q[0]) ?
                    w_data_q[`UMR_IRQ_W-1:0] : {`UMR_IRQ_W{1'b0}};
  // ------------------------------------------------------------
  // status, interrupt and outputs
  // ------------------------------------------------------------
  // event set beats a write-one-to-clear in the same cycle
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rx_req_q <= 1'b0;
      tx_req_q <= 1'b0;
      irq_stat_q <= {`UMR_IRQ_W{1'b0}};
      IRQ <= 1'b0;
      FIFO_DEPTH_16 <= 1'b0;
      BAUD_GROUP <= `UMR_BAUD_NORM;
      RX_DATA_AVAILABLE <= 1'b0;
      TX_SPACE_AVAILABLE <= 1'b0;
    end else begin
      rx_req_q <= rx_avail;
      tx_req_q <= tx_req && TX_ENABLE;
      irq_stat_q <= (irq_stat_q & ~clr_bits) | irq_evt;
      IRQ <= |(irq_stat_q & irq_mask_q);
      FIFO_DEPTH_16 <= mode0_q[`UMR_DEPTH_BIT];
      // test bit excluded; undefined codes fall back to normal
      case ({mode0_q[2], 1'b0, mode0_q[0]})
        `UMR_BAUD_EXT1: BAUD_GROUP <= `UMR_BAUD_EXT1;
        `UMR_BAUD_EXT2: BAUD_GROUP <= `UMR_BAUD_EXT2;
        default: BAUD_GROUP <= `UMR_BAUD_NORM;
      endcase
      RX_DATA_AVAILABLE <= rx_avail;
      TX_SPACE_AVAILABLE <= tx_req && TX_ENABLE;
    end
  end
  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  always @* begin
    rd_d = 32'h0;
    rresp_d = 2'h0;
    case ({S_AXI_ARADDR[3:2], 2'h0})
      `UMR_OFF_MODE0: rd_d = {24'h0, ptr_zero_q ? mode0_q : mode1_q};
      `UMR_OFF_MODE1: rd_d = {24'h0, mode1_q};
      `UMR_OFF_CMD: rd_d = {31'h0, ptr_zero_q};
      `UMR_OFF_STAT: rd_d = {16'h0, 5'h0, irq_mask_q, 5'h0, irq_stat_q};
      default: rresp_d = 2'h2;
    endcase
  end
  // one read at a time, answered the cycle after the address
  always @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'h0;
    end else begin
      // ready must not wait for valid low, or a held request stalls
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_d;
        S_AXI_RRESP <= rresp_d;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule // umr_ctrl

// [testbench/umr_ctrl_props.sv]
// Purpose: port checks for the mode-zero control block
// Assumes: one clock, NRST asynchronous and active low
// Notes: level checks wait two steady cycles for the latch
`timescale 1ns/1ps
module umr_ctrl_props (
  // clock and reset
  input wire CLK_SYS,
  input wire NRST,
  // bus handshakes
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID,
  // fifo side and outputs
  input wire [4:0] RX_LEVEL,
  input wire [4:0] TX_LEVEL,
  input wire TX_ENABLE,
  input wire FIFO_DEPTH_16,
  input wire [2:0] BAUD_GROUP,
  input wire RX_DATA_AVAILABLE,
  input wire TX_SPACE_AVAILABLE
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  // ----
  // bus answers
  // ----
  sequence s_wtake;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rtake;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  AST_WRESP: assert property (s_wtake |-> ##2 S_AXI_BVALID)
    else $error("write answer late");
  AST_RRESP: assert property (s_rtake |=> S_AXI_RVALID)
    else $error("read answer late");
  // settings may move only beside a write answer
  AST_CFG: assert property (
    $changed(FIFO_DEPTH_16) || $changed(BAUD_GROUP) |-> $past(S_AXI_BVALID))
    else $error("setting moved without a write");
  AST_BAUD: assert property (
    BAUD_GROUP == 3'h0 || BAUD_GROUP == 3'h1 || BAUD_GROUP == 3'h4)
    else $error("undefined baud group driven");
  // ----
  // fifo levels
  // ----
  AST_TXOFF: assert property (!TX_ENABLE |=> !TX_SPACE_AVAILABLE)
    else $error("tx request while disabled");
  AST_TX_ALL_EMPTY: assert property (
    (TX_ENABLE && TX_LEVEL == 5'h00) [*2] |=> TX_SPACE_AVAILABLE)
    else $error("empty tx fifo not flagged");
  AST_TXFULL: assert property (
    (FIFO_DEPTH_16 && TX_LEVEL == 5'h10) [*2] |=> !TX_SPACE_AVAILABLE)
    else $error("full tx fifo flagged");
  AST_RX_FIFO_FULL: assert property (
    (RX_LEVEL == 5'h10) [*2] |=> RX_DATA_AVAILABLE)
    else $error("full rx fifo not flagged");
endmodule // umr_ctrl_props

// [testbench/umr_tick_model.sv]
// Purpose: receiver 1x bit clock from the channel side
// Assumes: phase unrelated to the system clock
// Notes: stands still while run is low
`timescale 1ns/1ps
module umr_tick_model #(
  parameter integer HALF_NS = 21
) (
  // control
  input wire run,
  // bit clock
  output logic tick
);
  // toggle only while running so idle time adds no bits
  initial begin
    tick = 1'b0;
    forever begin
      #(HALF_NS);
      if (run) tick = ~tick;
    end
  end
endmodule // umr_tick_model

// [testbench/tb_uart_fifo_irq_level_ctrl.sv]
// Purpose: register-level tests of the mode-zero block
// Assumes: AXI4-Lite master, 4 ns clock, 42 ns bit time
// Notes: levels are driven directly, strobes where needed
`timescale 1ns/1ps
module tb_uart_fifo_irq_level_ctrl;
  // ----
  // wiring
  // ----
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic rxrd = 1'b0, rxch = 1'b0, txwr = 1'b0, txen = 1'b0, run = 1'b0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [4:0] rxl = 5'h0, txl = 5'h0;
  logic awr, wrdy, bv, arr, rv, dep, rxav, txav, irq, tick, m;
  logic [1:0] brsp, rrsp;
  logic [2:0] baud;
  integer miscompares = 0;
  integer cmp_count = 0;
  integer i, dd;
  integer rth [0:7] = '{1, 3, 6, 8, 1, 8, 12, 16};
  integer tth [0:7] = '{8, 4, 6, 1, 16, 8, 12, 1};
  logic [2:0] bin [0:3] = '{3'h0, 3'h1, 3'h4, 3'h5};
  logic [2:0] bout [0:3] = '{3'h0, 3'h1, 3'h4, 3'h0};
  umr_ctrl umr_ctrl_i (
    .CLK_SYS(clk), .NRST(nrst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(brsp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rrsp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .RX_LEVEL(rxl), .TX_LEVEL(txl), .RX_FIFO_READ(rxrd),
    .RX_CHAR_IN(rxch), .TX_FIFO_WRITE(txwr), .TX_ENABLE(txen),
    .RX_BIT_TICK(tick), .FIFO_DEPTH_16(dep), .BAUD_GROUP(baud),
    .RX_DATA_AVAILABLE(rxav), .TX_SPACE_AVAILABLE(txav), .IRQ(irq)
  );
  umr_tick_model umr_tick_model_i (.run(run), .tick(tick));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task automatic results;
    begin
      $display("miscompares %0d of %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw;
    begin
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      while (!(ta && tw)) begin
        @(posedge clk);
        if (awr && !ta) begin
          ta = 1'b1;
          awv <= 1'b0;
        end
        if (wrdy && !tw) begin
          tw = 1'b1;
          wv <= 1'b0;
        end
      end
      while (!bv) @(posedge clk);
      chk({30'h0, brsp}, 32'h0);
      br <= 1'b0;
      // registered outputs settle after this edge's updates
      #1;
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    begin
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      @(posedge clk);
      while (!arr) @(posedge clk);
      arv <= 1'b0;
      @(posedge clk);
      while (!rv) @(posedge clk);
      d = rdat;
      chk({30'h0, rrsp}, 32'h0);
      rr <= 1'b0;
    end
  endtask
  // new levels, with an optional strobe; read strobe, char strobe or tx write strobe
  task automatic lv(input logic [4:0] r, input logic [4:0] t,
                    input logic [2:0] s);
    begin
      @(posedge clk);
      rxl <= r;
      txl <= t;
      {rxrd, rxch, txwr} <= s;
      @(posedge clk);
      {rxrd, rxch, txwr} <= 3'h0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  // ----
  // clock, hang guard, sequence
  // ----
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares = miscompares + 1;
    results;
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(4'h8, v);
    chk(v & 32'h1, 32'h0);
    wr(4'h0, 32'h08);
    chk({31'h0, dep}, 32'h0);
    wr(4'h8, 32'hB0);
    rd(4'h8, v);
    chk(v & 32'h1, 32'h1);
    wr(4'h0, 32'h0B);
    chk({31'h0, dep}, 32'h1);
    rd(4'h0, v);
    chk(v & 32'hFF, 32'h09);
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h0, {29'h0, bin[i]});
      chk({29'h0, baud}, {29'h0, bout[i]});
    end
    // every depth and code pair, latched while both fifos are empty
    txen <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      dd = 8 << i[2];
      lv(5'h0, 5'h0, 3'h0);
      wr(4'h0, {24'h0, 1'b0, i[1], i[1:0], i[2], 3'h0});
      wr(4'h4, {25'h0, i[0], 6'h0});
      lv(5'(rth[i] - 1), 5'(dd - tth[i] + 1), 3'h0);
      chk({30'h0, rxav, txav}, 32'h0);
      lv(5'(rth[i]), 5'(dd - tth[i]), 3'h0);
      chk({30'h0, rxav, txav}, 32'h3);
    end
    lv(5'h0, 5'h0, 3'h0);
    wr(4'h0, 32'h0);
    lv(5'h0, 5'h1, 3'h1);
    chk({31'h0, txav}, 32'h0);
    wr(4'h0, 32'h30);
    chk({31'h0, txav}, 32'h0);
    lv(5'h0, 5'h2, 3'h1);
    chk({31'h0, txav}, 32'h1);
    // only the tx bit stays pending; flip its mask bit
    wr(4'hC, 32'h007);
    repeat (3) @(posedge clk);
    m = irq;
    wr(4'hC, 32'h207);
    repeat (3) @(posedge clk);
    chk({31'h0, irq ^ m}, 32'h1);
    wr(4'hC, m ? 32'h007 : 32'h207);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    txen <= 1'b0;
    wr(4'hC, m ? 32'h007 : 32'h207);
    repeat (3) @(posedge clk);
    chk({30'h0, irq, txav}, 32'h0);
    rd(4'hC, v);
    chk(v & 32'h7, 32'h0);
    // watchdog: rx threshold 8, two bytes left waiting
    lv(5'h0, 5'h0, 3'h0);
    wr(4'h0, 32'hC0);
    run <= 1'b1;
    lv(5'h1, 5'h0, 3'h2);
    repeat (420) @(posedge clk);
    lv(5'h2, 5'h0, 3'h2);
    repeat (420) @(posedge clk);
    chk({31'h0, rxav}, 32'h0);
    repeat (315) @(posedge clk);
    chk({31'h0, rxav}, 32'h1);
    rd(4'hC, v);
    chk(v & 32'h5, 32'h5);
    lv(5'h1, 5'h0, 3'h4);
    chk({31'h0, rxav}, 32'h0);
    run <= 1'b0;
    results;
  end
endmodule // tb_uart_fifo_irq_level_ctrl
bind umr_ctrl umr_ctrl_props umr_ctrl_props_i (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .RX_LEVEL(RX_LEVEL), .TX_LEVEL(TX_LEVEL),
  .TX_ENABLE(TX_ENABLE), .FIFO_DEPTH_16(FIFO_DEPTH_16),
  .BAUD_GROUP(BAUD_GROUP), .RX_DATA_AVAILABLE(RX_DATA_AVAILABLE),
  .TX_SPACE_AVAILABLE(TX_SPACE_AVAILABLE)
);
